// ==== rtl/axil_reg_port.sv ====
`include "irq_flags_map.svh"
module axil_reg_port (
  input wire logic clk_in,                         // System clock
  input wire logic srst_in,                        // Sync reset
  input wire logic awvalid_in,                     // Write address valid
  output logic awready_out,                        // Write address ready
  input wire logic [`IFR_ADDR_W-1:0] awaddr_in,    // Write address
  input wire logic wvalid_in,                      // Write data valid
  output logic wready_out,                         // Write data ready
  input wire logic [`IFR_DATA_W-1:0] wdata_in,     // Write data
  input wire logic [`IFR_STRB_W-1:0] wstrb_in,     // Byte strobes
  output logic bvalid_out,                         // Write response valid
  input wire logic bready_in,                      // Write response ready
  output logic [1:0] bresp_out,                    // Write response
  input wire logic arvalid_in,                     // Read address valid
  output logic arready_out,                        // Read address ready
  input wire logic [`IFR_ADDR_W-1:0] araddr_in,    // Read address
  output logic rvalid_out,                         // Read data valid
  input wire logic rready_in,                      // Read data ready
  output logic [`IFR_DATA_W-1:0] rdata_out,        // Read data
  output logic [1:0] rresp_out,                    // Read response
  output irq_flags_pkg::reg_wr_t reg_wr_out,       // Register write strobe
  input wire logic wr_hit_in,                      // Write address mapped
  output logic [`IFR_ADDR_W-1:0] rd_addr_out,      // Read address to decode
  input wire logic [`IFR_REG_W-1:0] rd_data_in,    // Decoded read value
  input wire logic rd_hit_in                       // Read address mapped
);
  logic aw_held_q, aw_held_d; // Address captured
  logic w_held_q, w_held_d; // Data captured
  logic [`IFR_ADDR_W-1:0] waddr_q, waddr_d; // Captured address
  logic [`IFR_REG_W-1:0] wdata_q, wdata_d; // Captured low byte
  logic wstrb0_q, wstrb0_d; // Low lane strobe
  logic bvalid_q, bvalid_d; // Response pending
  logic [1:0] bresp_q, bresp_d; // Response code
  logic rvalid_q, rvalid_d; // Read data pending
  logic [`IFR_DATA_W-1:0] rdata_q, rdata_d; // Read data
  logic [1:0] rresp_q, rresp_d; // Read code
  logic do_write; // Both halves present
  ////////////////////////////////////////////////////////////////
  // Channel capture and responses
  always_comb begin
    awready_out = !aw_held_q && !bvalid_q;
    wready_out = !w_held_q && !bvalid_q;
    arready_out = !rvalid_q;
    do_write = aw_held_q && w_held_q && !bvalid_q;
    reg_wr_out.en = do_write && wstrb0_q;
    reg_wr_out.addr = waddr_q;
    reg_wr_out.data = wdata_q;
    rd_addr_out = araddr_in;
    {aw_held_d, w_held_d, waddr_d, wdata_d, wstrb0_d} = {aw_held_q, w_held_q, waddr_q, wdata_q, wstrb0_q};
    {bvalid_d, bresp_d, rvalid_d, rdata_d, rresp_d} = {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q};
    if (awvalid_in && awready_out) begin // Address taken
      aw_held_d = 1'b1;
      waddr_d = awaddr_in;
    end
    if (wvalid_in && wready_out) begin // Data taken
      w_held_d = 1'b1;
      wdata_d = wdata_in[`IFR_REG_W-1:0];
      wstrb0_d = wstrb_in[0];
    end
    if (do_write) begin // Commit and answer
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit_in ? `IFR_RESP_OKAY : `IFR_RESP_SLVERR;
    end else if (bvalid_q && bready_in) begin
      bvalid_d = 1'b0;
    end
    if (arvalid_in && arready_out) begin // Read taken
      rvalid_d = 1'b1;
      rdata_d = {{`IFR_PAD_W{1'b0}}, rd_data_in};
      rresp_d = rd_hit_in ? `IFR_RESP_OKAY : `IFR_RESP_SLVERR;
    end else if (rvalid_q && rready_in) begin
      rvalid_d = 1'b0;
    end
    bvalid_out = bvalid_q;
    bresp_out = bresp_q;
    rvalid_out = rvalid_q;
    rdata_out = rdata_q;
    rresp_out = rresp_q;
  end
  ////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      {aw_held_q, w_held_q, waddr_q, wdata_q, wstrb0_q} <= '0;
      {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q} <= '0;
    end else begin
      {aw_held_q, w_held_q, waddr_q, wdata_q, wstrb0_q} <= {aw_held_d, w_held_d, waddr_d, wdata_d, wstrb0_d};
      {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q} <= {bvalid_d, bresp_d, rvalid_d, rdata_d, rresp_d};
    end
  end
endmodule // axil_reg_port

// ==== rtl/interrupt_flag_registers.sv ====
`include "irq_flags_map.svh"
// Summary of operation
// - Second serial receive sets bit 7, vector clears
// - Converter sets bit 5, vector clears it
// - First serial receive sets bit 3, vector clears
// - Radio FIFO error sets bit 1, vector clears
// - Bits 2 and 0 stay one always
// - Either crypto flag requests encryption service
// - Crypto request sets both crypto flags together
// - Either radio flag requests radio service
// - Radio request sets both radio flags together
// - Upper pair-register bits reset zero, no effect
// - Flags set regardless of enable bits
// - Enabled pending flag forces call next cycle when idle
module interrupt_flag_registers (
  input wire logic clk_in,                         // System clock
  input wire logic srst_in,                        // Sync reset, active high
  input irq_flags_pkg::irq_events_t events_in,     // Peripheral event pulses
  output logic forced_vector_call_out,             // One-cycle call request to core
  output logic [`IFR_ID_W-1:0] vector_id_out,      // Source being called
  input wire logic vector_ack_in,                  // Core has vectored
  input wire logic service_done_in,                // Core returned from service
  output logic irq_out,                            // Unmasked event status
  input wire logic awvalid_in,                     // Write address valid
  output logic awready_out,                        // Write address ready
  input wire logic [`IFR_ADDR_W-1:0] awaddr_in,    // Write address
  input wire logic wvalid_in,                      // Write data valid
  output logic wready_out,                         // Write data ready
  input wire logic [`IFR_DATA_W-1:0] wdata_in,     // Write data
  input wire logic [`IFR_STRB_W-1:0] wstrb_in,     // Byte strobes
  output logic bvalid_out,                         // Write response valid
  input wire logic bready_in,                      // Write response ready
  output logic [1:0] bresp_out,                    // Write response
  input wire logic arvalid_in,                     // Read address valid
  output logic arready_out,                        // Read address ready
  input wire logic [`IFR_ADDR_W-1:0] araddr_in,    // Read address
  output logic rvalid_out,                         // Read data valid
  input wire logic rready_in,                      // Read data ready
  output logic [`IFR_DATA_W-1:0] rdata_out,        // Read data
  output logic [1:0] rresp_out                     // Read response
);
  ////////////////////////////////////////////////////////////////
  // Declarations
  // Bus side
  irq_flags_pkg::reg_wr_t reg_wr; // Write strobe from bus port
  logic [`IFR_ADDR_W-1:0] rd_addr; // Read address to decode
  logic [`IFR_REG_W-1:0] rd_data; // Read value
  irq_flags_pkg::sel_t sel_wr, sel_rd; // Decoded selections
  // Flag and control storage
  logic [`IFR_REG_W-1:0] flags_a_q, flags_a_d; // First flag register
  logic [`IFR_REG_W-1:0] crypto_q, crypto_d; // Encryption flag register
  logic [`IFR_REG_W-1:0] radio_q, radio_d; // Radio flag register
  logic [`IFR_REG_W-1:0] en_q, en_d; // Enable register
  logic [`IFR_NSRC-1:0] stat_q, stat_d; // Sticky event status
  logic [`IFR_NSRC-1:0] mask_q, mask_d; // Status mask
  // Request path
  logic [`IFR_NSRC-1:0] ev_vec; // Events as a vector
  logic [`IFR_NSRC-1:0] pend; // Pending per source
  logic [`IFR_NSRC-1:0] req; // Pending and enabled
  logic [`IFR_NSRC-1:0] vec_clr; // Vector clear, one-hot
  logic pick_any; // Some request present
  logic [`IFR_ID_W-1:0] pick_id; // Chosen source
  // Vectoring
  irq_flags_pkg::vstate_t vstate_q, vstate_d; // Vectoring state
  logic [`IFR_ID_W-1:0] vid_q, vid_d; // Latched source

  ////////////////////////////////////////////////////////////////
  // Helpers
  // Address to register selection, for writes and reads
  function automatic irq_flags_pkg::sel_t decode(input logic [`IFR_ADDR_W-1:0] addr);
    irq_flags_pkg::sel_t s;
    s = irq_flags_pkg::SEL_NONE;
    if (addr == {`IFR_IDX_A, 2'h0}) s = irq_flags_pkg::SEL_A;
    if (addr == {`IFR_IDX_CRYPTO, 2'h0}) s = irq_flags_pkg::SEL_CRYPTO;
    if (addr == {`IFR_IDX_RADIO, 2'h0}) s = irq_flags_pkg::SEL_RADIO;
    if (addr == {`IFR_IDX_EN, 2'h0}) s = irq_flags_pkg::SEL_EN;
    if (addr == {`IFR_IDX_STAT, 2'h0}) s = irq_flags_pkg::SEL_STAT;
    if (addr == {`IFR_IDX_MASK, 2'h0}) s = irq_flags_pkg::SEL_MASK;
    return s;
  endfunction

  // Bit position in the first flag register of a cleared-on-vector source
  function automatic int a_pos(input int src);
    int p;
    p = `IFR_A_SERB;
    if (src == 1) p = `IFR_A_CONV;
    if (src == 2) p = `IFR_A_SERA;
    if (src == 3) p = `IFR_A_FERR;
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Bus slave and request picker
  // Register bus slave
  axil_reg_port u_port (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .awaddr_in(awaddr_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .bresp_out(bresp_out),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .araddr_in(araddr_in),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .reg_wr_out(reg_wr),
    .wr_hit_in(sel_wr != irq_flags_pkg::SEL_NONE),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_hit_in(sel_rd != irq_flags_pkg::SEL_NONE)
  );

  // Lowest index wins among enabled requests
  vector_picker u_pick (
    .req_in(req),
    .any_out(pick_any),
    .id_out(pick_id)
  );

  ////////////////////////////////////////////////////////////////
  // Request view and read mux
  always_comb begin
    ev_vec = events_in;
    sel_wr = decode(reg_wr.addr);
    sel_rd = decode(rd_addr);
    // Pending view per source
    for (int i = 0; i < `IFR_NH0; i++) begin
      pend[i] = flags_a_q[a_pos(i)];
    end
    pend[`IFR_SRC_CRYPTO] = |(crypto_q & `IFR_PAIR_MASK);
    pend[`IFR_SRC_RADIO] = |(radio_q & `IFR_PAIR_MASK);
    req = pend & en_q[`IFR_NSRC-1:0] & {`IFR_NSRC{en_q[`IFR_EN_GLOBAL]}};
    // Read multiplexer
    rd_data = '0;
    unique case (sel_rd)
      irq_flags_pkg::SEL_A: rd_data = flags_a_q;
      irq_flags_pkg::SEL_CRYPTO: rd_data = crypto_q;
      irq_flags_pkg::SEL_RADIO: rd_data = radio_q;
      irq_flags_pkg::SEL_EN: rd_data = en_q;
      irq_flags_pkg::SEL_STAT: rd_data = {2'h0, stat_q};
      irq_flags_pkg::SEL_MASK: rd_data = {2'h0, mask_q};
      irq_flags_pkg::SEL_NONE: rd_data = '0; // Unmapped reads zero
    endcase
    // Level interrupt from unmasked status
    irq_out = |(stat_q & mask_q);
  end

  ////////////////////////////////////////////////////////////////
  // Flag next values: write, then hardware clear, then hardware set
  always_comb begin
    flags_a_d = flags_a_q;
    crypto_d = crypto_q;
    radio_d = radio_q;
    en_d = en_q;
    stat_d = stat_q;
    mask_d = mask_q;
    // Software write first, hardware overrides it below
    if (reg_wr.en) begin
      unique case (sel_wr)
        irq_flags_pkg::SEL_A: flags_a_d = reg_wr.data;
        irq_flags_pkg::SEL_CRYPTO: crypto_d = reg_wr.data;
        irq_flags_pkg::SEL_RADIO: radio_d = reg_wr.data;
        irq_flags_pkg::SEL_EN: en_d = reg_wr.data;
        irq_flags_pkg::SEL_STAT: stat_d = stat_q & ~reg_wr.data[`IFR_NSRC-1:0];
        irq_flags_pkg::SEL_MASK: mask_d = reg_wr.data[`IFR_NSRC-1:0];
        irq_flags_pkg::SEL_NONE: en_d = en_q; // Unmapped, nothing stored
      endcase
    end
    // Vector clear, then event set per source
    for (int i = 0; i < `IFR_NH0; i++) begin
      if (vec_clr[i]) begin
        flags_a_d[a_pos(i)] = 1'b0;
      end
      if (ev_vec[i]) begin
        flags_a_d[a_pos(i)] = 1'b1;
      end
    end
    // Reserved ones cannot be written away
    flags_a_d = flags_a_d | `IFR_A_RSV_MASK;
    // Pair flags rise together on a request
    if (events_in.crypto) begin
      crypto_d = crypto_d | `IFR_PAIR_MASK;
    end
    if (events_in.radio_gen) begin
      radio_d = radio_d | `IFR_PAIR_MASK;
    end
    stat_d = stat_d | ev_vec; // Set wins over clear
  end

  ////////////////////////////////////////////////////////////////
  // Vectoring sequence toward the core
  always_comb begin
    vstate_d = vstate_q;
    vid_d = vid_q;
    vec_clr = '0;
    unique case (vstate_q)
      irq_flags_pkg::VS_IDLE: begin
        if (pick_any) begin
          // Latch the winner
          vid_d = pick_id;
          vstate_d = irq_flags_pkg::VS_CALL;
        end
      end
      irq_flags_pkg::VS_CALL: begin
        // Call lasts one cycle
        vstate_d = irq_flags_pkg::VS_WAIT;
      end
      irq_flags_pkg::VS_WAIT: begin
        // Wait for the core to vector
        if (vector_ack_in) begin
          vec_clr = `IFR_NSRC'(1) << vid_q;
          vstate_d = irq_flags_pkg::VS_SERVICE;
        end
      end
      irq_flags_pkg::VS_SERVICE: begin
        // Hold off new calls until return
        if (service_done_in) begin
          vstate_d = irq_flags_pkg::VS_IDLE;
        end
      end
    endcase
    forced_vector_call_out = (vstate_q == irq_flags_pkg::VS_CALL);
    vector_id_out = vid_q;
  end

  ////////////////////////////////////////////////////////////////
  // State registers
  // Flag, enable, status and mask storage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flags_a_q <= `IFR_RST_A;
      crypto_q <= `IFR_RST_PAIR;
      radio_q <= `IFR_RST_PAIR;
      en_q <= `IFR_RST_EN;
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      flags_a_q <= flags_a_d;
      crypto_q <= crypto_d;
      radio_q <= radio_d;
      en_q <= en_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // Vectoring state and latched source
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      vstate_q <= irq_flags_pkg::VS_IDLE;
      vid_q <= '0;
    end else begin
      vstate_q <= vstate_d;
      vid_q <= vid_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  // Every check runs on the system clock, off during reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // Call, then the wait state in the next cycle
  sequence call_then_wait_s;
    forced_vector_call_out ##1 (vstate_q == irq_flags_pkg::VS_WAIT);
  endsequence
  // The core answers in the wait state
  sequence ack_in_wait_s;
    (vstate_q == irq_flags_pkg::VS_WAIT) && vector_ack_in;
  endsequence

  // Second serial event always lands
  serb_set_a: assert property (events_in.serial_b_rx |=> flags_a_q[`IFR_A_SERB])
    else $error("second serial flag not set");

  // Converter flag drops when its vector is taken
  conv_clear_a: assert property (ack_in_wait_s ##0 (vid_q == 3'h1) ##0 !events_in.converter
    |=> !flags_a_q[`IFR_A_CONV])
    else $error("converter flag not cleared on vector");

  // First serial event always lands
  sera_set_a: assert property (events_in.serial_a_rx |=> flags_a_q[`IFR_A_SERA])
    else $error("first serial flag not set");

  // FIFO error flag drops when its vector is taken
  ferr_clear_a: assert property (ack_in_wait_s ##0 (vid_q == 3'h3) ##0 !events_in.radio_fifo_err
    |=> !flags_a_q[`IFR_A_FERR])
    else $error("fifo error flag not cleared on vector");

  // Reserved bits never read zero
  rsvd_one_a: assert property ((flags_a_q & `IFR_A_RSV_MASK) == `IFR_A_RSV_MASK)
    else $error("reserved bits not one");

  // A set crypto flag, alone and enabled, gets the crypto vector
  crypto_req_a: assert property ((vstate_q == irq_flags_pkg::VS_IDLE) && crypto_q[1] && en_q[`IFR_EN_GLOBAL]
    && en_q[`IFR_SRC_CRYPTO] && (req[`IFR_SRC_CRYPTO-1:0] == '0)
    |=> forced_vector_call_out && (vector_id_out == `IFR_SRC_CRYPTO))
    else $error("crypto flag gives no request");

  // Crypto request fills both flags
  crypto_both_a: assert property (events_in.crypto |=> crypto_q[1:0] == 2'h3)
    else $error("crypto flags not both set");

  // A set radio flag, alone and enabled, gets the radio vector
  radio_req_a: assert property ((vstate_q == irq_flags_pkg::VS_IDLE) && radio_q[0] && en_q[`IFR_EN_GLOBAL]
    && en_q[`IFR_SRC_RADIO] && (req[`IFR_SRC_RADIO-1:0] == '0)
    |=> forced_vector_call_out && (vector_id_out == `IFR_SRC_RADIO))
    else $error("radio flag gives no request");

  // Radio request fills both flags, upper bits untouched
  radio_both_a: assert property (events_in.radio_gen && !(reg_wr.en && sel_wr == irq_flags_pkg::SEL_RADIO)
    |=> $stable(radio_q[7:2]) && radio_q[1:0] == 2'h3)
    else $error("radio flags not both set");

  // Clearing the pair through a write ends the request
  unused_bits_a: assert property (reg_wr.en && sel_wr == irq_flags_pkg::SEL_CRYPTO && reg_wr.data[1:0] == 2'h0
    && !events_in.crypto |=> !pend[`IFR_SRC_CRYPTO])
    else $error("unused bits raised request");

  // Flags latch with their enable off
  set_unenabled_a: assert property (events_in.converter && !en_q[1] |=> flags_a_q[`IFR_A_CONV])
    else $error("flag not set while disabled");

  // An enabled request in idle forces the call next cycle
  call_next_a: assert property ((vstate_q == irq_flags_pkg::VS_IDLE) && (|req) |=> call_then_wait_s)
    else $error("call not forced next cycle");

  // Hardware set survives a same-cycle write
  set_wins_a: assert property (reg_wr.en && sel_wr == irq_flags_pkg::SEL_A && events_in.serial_b_rx
    |=> flags_a_q[`IFR_A_SERB])
    else $error("set lost to clear");
endmodule // interrupt_flag_registers

// ==== rtl/irq_flags_map.svh ====
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH
// Bus widths
`define IFR_ADDR_W 12
`define IFR_DATA_W 32
`define IFR_STRB_W 4
`define IFR_REG_W 8
`define IFR_PAD_W 24
`define IFR_RESP_OKAY 2'h0
`define IFR_RESP_SLVERR 2'h2
// Register indices, byte address is four times the index
`define IFR_IDX_W 10
`define IFR_IDX_A 10'h088
`define IFR_IDX_CRYPTO 10'h098
`define IFR_IDX_RADIO 10'h09B
`define IFR_IDX_EN 10'h0A0
`define IFR_IDX_STAT 10'h0A1
`define IFR_IDX_MASK 10'h0A2
// Sources and vector identifiers
`define IFR_NSRC 6
`define IFR_NH0 4
`define IFR_ID_W 3
`define IFR_SRC_CRYPTO 4
`define IFR_SRC_RADIO 5
// Bit positions in the first flag register
`define IFR_A_SERB 7
`define IFR_A_CONV 5
`define IFR_A_SERA 3
`define IFR_A_FERR 1
`define IFR_A_RSV_MASK 8'h05
// Paired flags and enable
`define IFR_PAIR_MASK 8'h03
`define IFR_EN_GLOBAL 7
// Reset values
`define IFR_RST_A 8'h05
`define IFR_RST_PAIR 8'h00
`define IFR_RST_EN 8'h00
`endif

// ==== rtl/irq_flags_pkg.sv ====
package irq_flags_pkg;
  // Peripheral event pulses, one bit per source
  typedef struct packed {
    logic radio_gen;      // General radio request
    logic crypto;         // Encryption coprocessor request
    logic radio_fifo_err; // Radio FIFO error
    logic serial_a_rx;    // First serial unit receive
    logic converter;      // Converter done
    logic serial_b_rx;    // Second serial unit receive
  } irq_events_t;
  // Internal register write strobe
  typedef struct packed {
    logic en;                    // Write this cycle
    logic [11:0] addr;           // Byte address
    logic [7:0] data;            // Low byte lane
  } reg_wr_t;
  // Register selected by an address
  typedef enum logic [2:0] {SEL_NONE, SEL_A, SEL_CRYPTO, SEL_RADIO, SEL_EN, SEL_STAT, SEL_MASK} sel_t;
  // Vectoring sequence
  typedef enum logic [1:0] {VS_IDLE, VS_CALL, VS_WAIT, VS_SERVICE} vstate_t;
endpackage

// ==== rtl/vector_picker.sv ====
`include "irq_flags_map.svh"
module vector_picker (
  input wire logic [`IFR_NSRC-1:0] req_in, // Enabled pending requests
  output logic any_out,                    // Some request present
  output logic [`IFR_ID_W-1:0] id_out      // Lowest index wins
);
  ////////////////////////////////////////////////////////////////
  // Fixed order, index zero first
  always_comb begin
    id_out = '0;
    for (int i = `IFR_NSRC - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        id_out = i[`IFR_ID_W-1:0];
      end
    end
    any_out = |req_in;
  end
endmodule // vector_picker

// ==== testbench/core_model.sv ====
////////////////////////////////////////
// Core side: takes forced calls, vectors, returns from service
module core_model (
  input wire logic clk_in,       // System clock
  input wire logic srst_in,      // Sync reset
  input wire logic call_in,      // Forced call pulse
  input wire logic [3:0] dly_in, // Answer delay in cycles
  output logic ack_out,          // Vectored pulse
  output logic done_out          // Return pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q; // 0 idle, 1 to vector, 2 to return
  logic [3:0] cnt_q; // Cycles left to wait
  ////////////////////////////////////////
  // Pulses last one cycle, delay set by the bench
  always_ff @(posedge clk_in) begin
    ack_out <= 1'b0;
    done_out <= 1'b0;
    if (srst_in) begin
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
    end else if (ph_q == 2'h0) begin
      if (call_in === 1'b1) begin
        ph_q <= 2'h1;
        cnt_q <= dly_in;
      end
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1; // Still waiting
    end else if (ph_q == 2'h1) begin
      ack_out <= 1'b1;
      ph_q <= 2'h2;
      cnt_q <= dly_in;
    end else begin
      done_out <= 1'b1; // Return from service
      ph_q <= 2'h0;
    end
  end
endmodule // core_model

// ==== testbench/tb_interrupt_flag_registers.sv ====
`include "irq_flags_map.svh"
module tb_interrupt_flag_registers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_AD = {`IFR_IDX_A, 2'h0};
  localparam logic [11:0] CR_AD = {`IFR_IDX_CRYPTO, 2'h0};
  localparam logic [11:0] RA_AD = {`IFR_IDX_RADIO, 2'h0};
  localparam logic [11:0] EN_AD = {`IFR_IDX_EN, 2'h0};
  localparam logic [11:0] ST_AD = {`IFR_IDX_STAT, 2'h0};
  localparam logic [11:0] MK_AD = {`IFR_IDX_MASK, 2'h0};
  localparam logic [1:0] OK = `IFR_RESP_OKAY;
  localparam logic [1:0] ERR = `IFR_RESP_SLVERR;
  logic clk_in, srst_in, awvalid, wvalid, bready, arvalid, rready, ack, done; // Bench drives
  logic awready, wready, bvalid, arready, rvalid, call, irq; // Design drives
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, dly;
  logic [1:0] bresp, rresp, r;
  logic [2:0] vid;
  irq_flags_pkg::irq_events_t events; // Peripheral pulses
  int n_mismatch, checked;
  logic [2:0] ids[$]; // Called sources in order
  logic [11:0] pa[2] = '{CR_AD, RA_AD};
  logic [7:0] pe[2] = '{8'h90, 8'hA0};
  logic [7:0] pf[2] = '{8'hFE, 8'h01};
  interrupt_flag_registers u_dut (.clk_in(clk_in), .srst_in(srst_in), .events_in(events),
    .forced_vector_call_out(call), .vector_id_out(vid), .vector_ack_in(ack), .service_done_in(done),
    .irq_out(irq), .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
    .wready_out(wready), .wdata_in(wdata), .wstrb_in(wstrb), .bvalid_out(bvalid), .bready_in(bready),
    .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
    .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp));
  core_model u_core (.clk_in(clk_in), .srst_in(srst_in), .call_in(call), .dly_in(dly),
    .ack_out(ack), .done_out(done));
  ////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Record every forced call
  always @(posedge clk_in) begin
    if (call === 1'b1) ids.push_back(vid);
  end
  ////////////////////////////////////////
  // Compare, count, report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Write one register, hold each channel until taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge clk_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // Read one register and compare data and response
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  // One-cycle event pulse
  task automatic ev(input logic [5:0] e);
    @(posedge clk_in);
    events <= irq_flags_pkg::irq_events_t'(e);
    @(posedge clk_in);
    events <= '0;
  endtask
  // Wait for a number of calls, then, if asked, for the core's return
  task automatic wait_svc(input int n, input logic need_done);
    int k;
    k = 0;
    while ((ids.size() < n || (need_done && done !== 1'b1)) && k < 400) begin
      @(posedge clk_in);
      k++;
    end
    chk({31'h0, k < 400}, 32'h1);
  endtask
  ////////////////////////////////////////
  // Tests
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    events = '0;
    dly = 4'h0;
    srst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rchk(A_AD, 32'h05, OK);
    rchk(CR_AD, 32'h00, OK);
    rchk(RA_AD, 32'h00, OK);
    rchk(EN_AD, 32'h00, OK);
    rchk(ST_AD, 32'h00, OK);
    rchk(MK_AD, 32'h00, OK);
    $display("test reset done");
    wr(A_AD, 8'h55, r);
    rchk(A_AD, 32'h55, OK);
    wr(12'h004, 8'hFF, r);
    chk({30'h0, r}, {30'h0, ERR});
    rchk(12'h004, 32'h0, ERR);
    $display("test bus done");
    for (int i = 0; i < 6; i++) ev(6'h01 << i);
    rchk(A_AD, 32'hFF, OK);
    rchk(CR_AD, 32'h03, OK);
    rchk(RA_AD, 32'h03, OK);
    rchk(ST_AD, 32'h3F, OK);
    chk({31'h0, irq}, 32'h0);
    wr(MK_AD, 8'h20, r);
    chk({31'h0, irq}, 32'h1);
    wr(ST_AD, 8'h20, r);
    chk({31'h0, irq}, 32'h0);
    rchk(ST_AD, 32'h1F, OK);
    $display("test events done");
    fork
      wr(A_AD, 8'h05, r);
      begin
        repeat (2) @(posedge clk_in);
        events <= irq_flags_pkg::irq_events_t'(6'h01);
        @(posedge clk_in);
        events <= '0;
      end
    join
    rchk(A_AD, 32'h85, OK);
    $display("test collide done");
    ev(6'h0F);
    wr(CR_AD, 8'h00, r);
    wr(RA_AD, 8'h00, r);
    wr(EN_AD, 8'h8F, r);
    wait_svc(4, 1'b1);
    for (int i = 0; i < 4; i++) chk({29'h0, ids[i]}, i);
    rchk(A_AD, 32'h05, OK);
    $display("test vector done");
    wr(EN_AD, 8'h90, r);
    wr(CR_AD, 8'hFC, r);
    repeat (30) @(posedge clk_in);
    chk(ids.size(), 4);
    rchk(CR_AD, 32'hFC, OK);
    dly <= 4'hF;
    for (int k = 0; k < 2; k++) begin
      wr(EN_AD, pe[k], r);
      wr(pa[k], pf[k], r);
      wait_svc(5 + k, 1'b0);
      wr(pa[k], 8'h00, r);
      wait_svc(5 + k, 1'b1);
      repeat (40) @(posedge clk_in);
      chk(ids.size(), 5 + k);
      chk({29'h0, ids[4 + k]}, 4 + k);
    end
    $display("test pairs done");
    conclude();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    conclude();
  end
endmodule // tb_interrupt_flag_registers
